// ===== inc/emb_pkg.sv
// Constants and types for the external memory bus interface.
// Assumes one 250 MHz clock and an active-low asynchronous reset.
package emb_pkg;
	localparam int EMB_ADDR_W = 24;
	localparam int EMB_DATA_W = 16;
	localparam int EMB_BYTE_W = 8;
	localparam int EMB_LOW_W = 16;
	localparam int EMB_CS_N = 4;
	localparam int EMB_CNT_W = 2;
	localparam int EMB_STROBE_CYC = 3;
	localparam logic [EMB_ADDR_W-1:0] EMB_ADDR_ONE = 24'h000001;
	localparam logic [EMB_ADDR_W-1:0] EMB_ADDR_ZERO = 24'h000000;
	localparam logic [EMB_DATA_W-1:0] EMB_DATA_ZERO = 16'h0000;
	localparam logic [EMB_CNT_W-1:0] EMB_CNT_ZERO = 2'h0;
	localparam logic [EMB_CNT_W-1:0] EMB_CNT_ONE = 2'h1;
	localparam logic [EMB_CS_N-1:0] EMB_CS_NONE = 4'h0;
	localparam logic [EMB_CS_N-1:0] EMB_CS_IDLE_N = 4'hF;
	typedef enum logic [2:0] {
		EMB_IDLE,
		EMB_ADDR,
		EMB_STROBE,
		EMB_HOLD,
		EMB_FINISH,
		EMB_FLOAT,
		EMB_GRANT,
		EMB_RESUME
	} emb_state_t;
endpackage

// ===== hdl/emb_external_bus.sv
// External memory bus: multiplexed address/data, strobes, chip selects, bus hand-over.
// Assumes requests come from logic on i_clock; pins and wait/request pass synchronisers.
// What this block does
// - Read strobe low in the strobe phase of every external read cycle, high in its address phase.
// - Outside bus hand-over, read strobe also low on internal reads when latch is 0 and select is 1.
// - Low write strobe low when a write drives the low eight lines.
// - High write strobe low when a write drives the upper eight lines.
// - Wait input held low stretches the strobe phase: N low cycles add N wait states.
// - On request, float the bus pins except address latch enable, then assert bus acknowledge.
// - Direction is 1 for read or idle cycles, 0 for write cycles.
// - Four chip selects; the lowest one whose programmed range the address hits goes low.
// - External controller gets no path into on-chip memory or peripherals.
// - Address 0-15 shares the data lines; address 16-23 on own outputs.
// - 16-Mbyte space; 8-bit ports get words as two byte cycles.
// - Address latch enable pulses per cycle; software can switch it off.
// - Address latch enable floats while reset is held.
`timescale 1ns/1ps
`default_nettype none
module emb_external_bus #(
	parameter int CS_N = emb_pkg::EMB_CS_N
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_req_valid,
	input wire logic i_req_write,
	input wire logic i_req_word,
	input wire logic [emb_pkg::EMB_ADDR_W-1:0] i_req_addr,
	input wire logic [emb_pkg::EMB_DATA_W-1:0] i_req_wdata,
	input wire logic i_int_read,
	input wire logic i_read_strobe_pin_latch,
	input wire logic i_read_strobe_pin_function_sel,
	input wire logic i_ale_enable,
	input wire logic [CS_N-1:0][emb_pkg::EMB_ADDR_W-1:0] i_cs_base,
	input wire logic [CS_N-1:0][emb_pkg::EMB_ADDR_W-1:0] i_cs_mask,
	input wire logic [CS_N-1:0] i_cs_bus16,
	input wire logic i_default_bus16,
	input wire logic [emb_pkg::EMB_DATA_W-1:0] i_muxed_addr_data_lines,
	input wire logic i_wait_n,
	input wire logic i_bus_request_n,
	output logic o_req_busy,
	output logic o_rsp_done,
	output logic [emb_pkg::EMB_DATA_W-1:0] o_rsp_rdata,
	output logic [emb_pkg::EMB_DATA_W-1:0] o_muxed_addr_data_lines,
	output logic o_muxed_addr_data_oe,
	output logic [emb_pkg::EMB_BYTE_W-1:0] o_upper_address_lines,
	output logic o_read_strobe_n,
	output logic o_low_byte_write_strobe_n,
	output logic o_high_byte_write_strobe_n,
	output logic o_read_write,
	output logic [CS_N-1:0] o_chip_select_n,
	output logic o_bus_ctrl_oe,
	output logic o_ale,
	output logic o_ale_oe,
	output logic o_bus_grant_ack_n
);
	import emb_pkg::*;

	// Lowest channel wins when ranges overlap
	function automatic logic [CS_N-1:0] cs_decode(
		input logic [EMB_ADDR_W-1:0] addr,
		input logic [CS_N-1:0][EMB_ADDR_W-1:0] base,
		input logic [CS_N-1:0][EMB_ADDR_W-1:0] mask
	);
		logic [CS_N-1:0] hit;
		logic found;
		hit = EMB_CS_NONE;
		found = 1'b0;
		for (int i = 0; i < CS_N; i++) begin
			if (!found && (((addr ^ base[i]) & mask[i]) == EMB_ADDR_ZERO)) begin
				hit[i] = 1'b1;
				found = 1'b1;
			end
		end
		return hit;
	endfunction

	// Two-flop synchronisers; first stage feeds only the second
	logic [EMB_DATA_W-1:0] ad_m_q, ad_s_q;
	logic wait_m_q, wait_s_q, breq_m_q, breq_s_q;
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ad_m_q <= EMB_DATA_ZERO;
			ad_s_q <= EMB_DATA_ZERO;
			wait_m_q <= 1'b1;
			wait_s_q <= 1'b1;
			breq_m_q <= 1'b1;
			breq_s_q <= 1'b1;
		end else begin
			ad_m_q <= i_muxed_addr_data_lines;
			ad_s_q <= ad_m_q;
			wait_m_q <= i_wait_n;
			wait_s_q <= wait_m_q;
			breq_m_q <= i_bus_request_n;
			breq_s_q <= breq_m_q;
		end
	end

	emb_state_t state_q, state_d;
	logic [EMB_CNT_W-1:0] cnt_q, cnt_d;
	logic [EMB_ADDR_W-1:0] addr_q, addr_d;
	logic [EMB_DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic wr_q, wr_d, word_q, word_d, split_q, split_d, bus16_q, bus16_d;
	logic [CS_N-1:0] hit_q, hit_d;
	logic done_q, done_d, busy_q, busy_d;
	logic [EMB_DATA_W-1:0] ad_q, ad_d;
	logic ad_oe_q, ad_oe_d, ctrl_oe_q, ctrl_oe_d;
	logic [EMB_BYTE_W-1:0] up_q, up_d;
	logic rd_n_q, rd_n_d, wr_n_q, wr_n_d, hwr_n_q, hwr_n_d, rw_q, rw_d;
	logic [CS_N-1:0] cs_n_q, cs_n_d;
	logic ale_q, ale_d, ale_oe_q, ale_oe_d, ack_n_q, ack_n_d;

	logic [CS_N-1:0] req_hit;
	logic in_cycle, in_strobe, lane_lo, lane_hi, odd, int_rd;
	logic [EMB_BYTE_W-1:0] rd_byte;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		wr_d = wr_q;
		word_d = word_q;
		split_d = split_q;
		bus16_d = bus16_q;
		hit_d = hit_q;
		done_d = 1'b0;
		req_hit = cs_decode(i_req_addr, i_cs_base, i_cs_mask);
		rd_byte = (bus16_q && addr_q[0]) ? ad_s_q[EMB_DATA_W-1:EMB_BYTE_W]
			: ad_s_q[EMB_BYTE_W-1:0];
		unique case (state_q)
			EMB_IDLE: begin
				if (!breq_s_q) begin
					state_d = EMB_FLOAT;
				end else if (i_req_valid) begin
					state_d = EMB_ADDR;
					addr_d = i_req_addr;
					wdata_d = i_req_wdata;
					wr_d = i_req_write;
					word_d = i_req_word;
					split_d = 1'b0;
					hit_d = req_hit;
					bus16_d = (req_hit == EMB_CS_NONE) ? i_default_bus16
						: |(req_hit & i_cs_bus16);
				end
			end
			EMB_ADDR: begin
				state_d = EMB_STROBE;
				cnt_d = EMB_CNT_ZERO;
			end
			EMB_STROBE: begin
				// Decision waits until the synchronised wait level is current
				if (cnt_q == EMB_CNT_W'(EMB_STROBE_CYC - 1)) begin
					state_d = wait_s_q ? EMB_FINISH : EMB_HOLD;
				end else begin
					cnt_d = cnt_q + EMB_CNT_ONE;
				end
			end
			EMB_HOLD: begin
				if (wait_s_q) begin
					state_d = EMB_FINISH;
				end
			end
			EMB_FINISH: begin
				// Own read data only; nothing here serves the outside master
				if (!wr_q) begin
					if (bus16_q && word_q) begin
						rdata_d = ad_s_q;
					end else if (addr_q[0]) begin
						rdata_d[EMB_DATA_W-1:EMB_BYTE_W] = rd_byte;
					end else begin
						rdata_d[EMB_BYTE_W-1:0] = rd_byte;
					end
				end
				if (word_q && !bus16_q && !split_q) begin
					split_d = 1'b1;
					addr_d = addr_q + EMB_ADDR_ONE;
					state_d = EMB_ADDR;
				end else begin
					done_d = 1'b1;
					state_d = EMB_IDLE;
				end
			end
			EMB_FLOAT: state_d = EMB_GRANT;
			EMB_GRANT: begin
				if (breq_s_q) begin
					state_d = EMB_RESUME;
				end
			end
			EMB_RESUME: state_d = EMB_IDLE;
		endcase
	end

	// Pin values follow the next state so every output is a flop
	always_comb begin
		in_cycle = (state_d == EMB_ADDR) || (state_d == EMB_STROBE)
			|| (state_d == EMB_HOLD) || (state_d == EMB_FINISH);
		in_strobe = (state_d == EMB_STROBE) || (state_d == EMB_HOLD)
			|| (state_d == EMB_FINISH);
		odd = addr_d[0];
		lane_hi = bus16_d && (word_d || odd);
		lane_lo = !bus16_d || word_d || !odd;
		ctrl_oe_d = (state_d != EMB_FLOAT) && (state_d != EMB_GRANT);
		ack_n_d = !((state_d == EMB_GRANT) || (state_d == EMB_RESUME));
		busy_d = (state_d != EMB_IDLE);
		int_rd = i_int_read && !i_read_strobe_pin_latch && i_read_strobe_pin_function_sel;
		// No strobe at all while acknowledge is still low, even in the resume cycle
		rd_n_d = !(ctrl_oe_d && ack_n_d && ((in_strobe && !wr_d) || int_rd));
		wr_n_d = !(in_strobe && wr_d && lane_lo);
		hwr_n_d = !(in_strobe && wr_d && lane_hi);
		rw_d = !(in_cycle && wr_d);
		cs_n_d = in_cycle ? ~hit_d : EMB_CS_IDLE_N;
		ale_d = i_ale_enable && (state_d == EMB_ADDR);
		ale_oe_d = 1'b1;
		up_d = addr_d[EMB_ADDR_W-1:EMB_LOW_W];
		ad_oe_d = ctrl_oe_d && ((state_d == EMB_ADDR) || (in_strobe && wr_d));
		if (state_d == EMB_ADDR) begin
			ad_d = addr_d[EMB_LOW_W-1:0];
		end else if (!bus16_d && odd) begin
			// Narrow port: odd byte moves to the low lanes
			ad_d = {wdata_d[EMB_DATA_W-1:EMB_BYTE_W], wdata_d[EMB_DATA_W-1:EMB_BYTE_W]};
		end else begin
			ad_d = wdata_d;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= EMB_IDLE;
			cnt_q <= EMB_CNT_ZERO;
			addr_q <= EMB_ADDR_ZERO;
			wdata_q <= EMB_DATA_ZERO;
			rdata_q <= EMB_DATA_ZERO;
			wr_q <= 1'b0;
			word_q <= 1'b0;
			split_q <= 1'b0;
			bus16_q <= 1'b0;
			hit_q <= EMB_CS_NONE;
			done_q <= 1'b0;
			busy_q <= 1'b0;
			ad_q <= EMB_DATA_ZERO;
			ad_oe_q <= 1'b0;
			ctrl_oe_q <= 1'b0;
			up_q <= '0;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			hwr_n_q <= 1'b1;
			rw_q <= 1'b1;
			cs_n_q <= EMB_CS_IDLE_N;
			ale_q <= 1'b0;
			ale_oe_q <= 1'b0;
			ack_n_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			wr_q <= wr_d;
			word_q <= word_d;
			split_q <= split_d;
			bus16_q <= bus16_d;
			hit_q <= hit_d;
			done_q <= done_d;
			busy_q <= busy_d;
			ad_q <= ad_d;
			ad_oe_q <= ad_oe_d;
			ctrl_oe_q <= ctrl_oe_d;
			up_q <= up_d;
			rd_n_q <= rd_n_d;
			wr_n_q <= wr_n_d;
			hwr_n_q <= hwr_n_d;
			rw_q <= rw_d;
			cs_n_q <= cs_n_d;
			ale_q <= ale_d;
			ale_oe_q <= ale_oe_d;
			ack_n_q <= ack_n_d;
		end
	end

	assign o_req_busy = busy_q;
	assign o_rsp_done = done_q;
	assign o_rsp_rdata = rdata_q;
	assign o_muxed_addr_data_lines = ad_q;
	assign o_muxed_addr_data_oe = ad_oe_q;
	assign o_upper_address_lines = up_q;
	assign o_read_strobe_n = rd_n_q;
	assign o_low_byte_write_strobe_n = wr_n_q;
	assign o_high_byte_write_strobe_n = hwr_n_q;
	assign o_read_write = rw_q;
	assign o_chip_select_n = cs_n_q;
	assign o_bus_ctrl_oe = ctrl_oe_q;
	assign o_ale = ale_q;
	assign o_ale_oe = ale_oe_q;
	assign o_bus_grant_ack_n = ack_n_q;
endmodule
`default_nettype wire

// ===== dv/emb_props.sv
// Port checker for the external bus.
// Assumes a bind from the bench and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module emb_props #(
	parameter int CS_N = 4
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic [23:0] i_req_addr,
	input wire logic i_ale_enable,
	input wire logic o_req_busy,
	input wire logic o_muxed_addr_data_oe,
	input wire logic [7:0] o_upper_address_lines,
	input wire logic o_read_strobe_n,
	input wire logic o_low_byte_write_strobe_n,
	input wire logic o_high_byte_write_strobe_n,
	input wire logic o_read_write,
	input wire logic [CS_N-1:0] o_chip_select_n,
	input wire logic o_bus_ctrl_oe,
	input wire logic o_ale,
	input wire logic o_ale_oe,
	input wire logic o_bus_grant_ack_n
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_reset_n);
	rd_hold_a: assert property (
		$fell(o_read_strobe_n) && o_req_busy |-> !o_read_strobe_n [*4])
		else $error("read strobe short");
	rd_dir_a: assert property (
		!o_read_strobe_n && o_req_busy |-> o_read_write) else $error("read dir");
	wr_dir_a: assert property (
		!(o_low_byte_write_strobe_n && o_high_byte_write_strobe_n)
		|-> !o_read_write && o_muxed_addr_data_oe) else $error("write dir");
	ack_float_a: assert property (
		$fell(o_bus_grant_ack_n) |-> !o_bus_ctrl_oe && !$past(o_bus_ctrl_oe)
		&& !o_muxed_addr_data_oe) else $error("ack before float");
	grant_quiet_a: assert property (
		!o_bus_grant_ack_n |-> o_req_busy && o_read_strobe_n && &o_chip_select_n)
		else $error("cycle while granted");
	addr_phase_a: assert property (
		$rose(o_req_busy) && o_bus_ctrl_oe |-> o_muxed_addr_data_oe
		&& o_ale == $past(i_ale_enable)
		&& o_upper_address_lines == 8'($past(i_req_addr) >> 16)) else $error("addr phase");
	cs_sel_a: assert property (
		$onehot0(~o_chip_select_n) && (o_req_busy || &o_chip_select_n))
		else $error("chip select");
	reset_float_a: assert property (disable iff (1'b0)
		!i_reset_n [*2] |-> !o_ale_oe && !o_bus_ctrl_oe) else $error("reset drive");
	cover property ($fell(o_bus_grant_ack_n));
	cover property ($rose(o_req_busy) && !o_read_write);
	cover property ($fell(o_read_strobe_n) && !o_req_busy);
endmodule
`default_nettype wire

// ===== dv/emb_mem_model.sv
// Far-side memory: data from latched address, wait on demand.
// Assumes the bench merges the lines with the device drive.
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model (
	input wire logic i_clock,
	input wire logic [15:0] i_ad,
	input wire logic i_ad_oe,
	input wire logic i_rd_n,
	input wire logic i_stb_n,
	input wire logic [1:0] i_wait_cyc,
	output logic [15:0] o_ad,
	output logic o_wait_n
);
	logic [15:0] addr_q;
	logic oe_q;
	logic [2:0] cnt_q;
	initial o_ad = 16'h0;
	always @(posedge i_clock) begin
		oe_q <= i_ad_oe;
		if (i_ad_oe && !oe_q) addr_q <= i_ad;
		cnt_q <= i_stb_n ? 3'h0 : cnt_q + 3'h1;
		// Released lines flip so stale data cannot pass
		o_ad <= (!i_rd_n && !i_ad_oe) ? addr_q ^ 16'hC3A5 : ~o_ad;
	end
	assign o_wait_n = i_stb_n || cnt_q >= {1'h0, i_wait_cyc};
endmodule
`default_nettype wire

// ===== dv/emb_external_bus_bench.sv
// Bench: access table, then strobe, hand-over and reset cases.
// Assumes the memory model on the lines and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module emb_external_bus_bench;
	typedef struct packed {
		logic w;
		logic wd;
		logic [23:0] a;
		logic [1:0] wt;
		logic [3:0] cy;
		logic [2:0] st;
		logic [3:0] cs;
		logic [15:0] d;
	} emb_row_t;
	logic i_clock, i_reset_n, i_req_valid, i_req_write, i_req_word, i_int_read, i_wait_n;
	logic i_read_strobe_pin_latch, i_read_strobe_pin_function_sel, i_ale_enable;
	logic i_default_bus16, i_bus_request_n, o_req_busy, o_rsp_done, o_muxed_addr_data_oe;
	logic o_read_strobe_n, o_read_write, o_low_byte_write_strobe_n, o_high_byte_write_strobe_n;
	logic o_bus_ctrl_oe, o_ale, o_ale_oe, o_bus_grant_ack_n;
	logic [23:0] i_req_addr;
	logic [15:0] i_req_wdata, o_rsp_rdata, o_muxed_addr_data_lines, mem_ad;
	logic [3:0][23:0] i_cs_base, i_cs_mask;
	logic [3:0] i_cs_bus16, o_chip_select_n;
	logic [7:0] o_upper_address_lines;
	logic [1:0] wt;
	int fails, num_checks;
	wire logic [15:0] i_muxed_addr_data_lines = o_muxed_addr_data_oe ?
		o_muxed_addr_data_lines : mem_ad;
	emb_row_t rows [10] = '{
		'{1'h0, 1'h1, 24'h001234, 2'h0, 4'h6, 3'h3, 4'hE, 16'hD191},
		'{1'h1, 1'h1, 24'h001236, 2'h0, 4'h6, 3'h4, 4'hE, 16'h1234},
		'{1'h1, 1'h0, 24'h001237, 2'h0, 4'h6, 3'h6, 4'hE, 16'h5600},
		'{1'h1, 1'h0, 24'h001238, 2'h0, 4'h6, 3'h5, 4'hE, 16'h0078},
		'{1'h0, 1'h1, 24'h010040, 2'h0, 4'hB, 3'h3, 4'hD, 16'hE4E5},
		'{1'h1, 1'h1, 24'h010042, 2'h0, 4'hB, 3'h5, 4'hD, 16'h9ABC},
		'{1'h0, 1'h0, 24'h200011, 2'h0, 4'h6, 3'h3, 4'hB, 16'hC300},
		'{1'h1, 1'h1, 24'h800000, 2'h0, 4'h6, 3'h4, 4'hF, 16'h0F0F},
		'{1'h0, 1'h1, 24'h020002, 2'h0, 4'h6, 3'h3, 4'h7, 16'hC3A7},
		'{1'h0, 1'h1, 24'h000100, 2'h3, 4'h9, 3'h3, 4'hE, 16'hC2A5}};
	emb_external_bus u_emb_external_bus (.*);
	emb_mem_model u_emb_mem_model (.i_clock, .i_ad(o_muxed_addr_data_lines),
		.i_ad_oe(o_muxed_addr_data_oe), .i_rd_n(o_read_strobe_n), .i_wait_cyc(wt),
		.i_stb_n(o_read_strobe_n & o_low_byte_write_strobe_n & o_high_byte_write_strobe_n),
		.o_ad(mem_ad), .o_wait_n(i_wait_n));
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task report_and_stop;
		if (fails == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic acc(emb_row_t r);
		int n;
		logic [2:0] st;
		logic [3:0] cs;
		logic rw;
		logic [15:0] m;
		logic [15:0] wd;
		n = 1;
		wd = 16'h0000;
		{st, cs, rw} = 8'hFF;
		m = r.wd ? 16'hFFFF : (r.a[0] ? 16'hFF00 : 16'h00FF);
		{i_req_valid, i_req_write, i_req_word, wt} = {1'h1, r.w, r.wd, r.wt};
		{i_req_addr, i_req_wdata} = {r.a, r.d};
		@(negedge i_clock);
		i_req_valid = 1'h0;
		while (o_rsp_done !== 1'h1 && n < 40) begin
			st &= {o_read_strobe_n, o_low_byte_write_strobe_n, o_high_byte_write_strobe_n};
			cs &= o_chip_select_n;
			rw &= o_read_write;
			// Split words leave the last byte on the low lanes
			if (!o_low_byte_write_strobe_n) wd[7:0] = o_muxed_addr_data_lines[7:0];
			if (!o_high_byte_write_strobe_n) wd[15:8] = o_muxed_addr_data_lines[15:8];
			@(negedge i_clock);
			n++;
		end
		chk("cycles", r.cy, n);
		chk("strobes", r.st, st);
		chk("chip_sel", r.cs, cs);
		chk("dir", !r.w, rw);
		if (!r.w) chk("rdata", r.d & m, o_rsp_rdata & m);
		else chk("wdata", r.cy > 6 ? {8'h00, r.d[15:8]} : r.d, wd);
	endtask
	task automatic wait_ack(logic v);
		for (int n = 0; n < 20 && o_bus_grant_ack_n !== v; n++) @(negedge i_clock);
		chk("ack", v, o_bus_grant_ack_n);
	endtask
	initial begin
		i_clock = 1'h0;
		forever #2 i_clock = ~i_clock;
	end
	initial begin
		#8000;
		fails++;
		report_and_stop();
	end
	initial begin
		{i_req_valid, i_req_write, i_req_word, i_int_read, i_reset_n, wt} = 7'h0;
		{i_read_strobe_pin_latch, i_read_strobe_pin_function_sel} = 2'h0;
		{i_ale_enable, i_default_bus16, i_bus_request_n} = 3'h7;
		{i_req_addr, i_req_wdata} = 40'h0;
		i_cs_base = {24'h000000, 24'h200000, 24'h010000, 24'h000000};
		i_cs_mask = {24'hF00000, 24'hFF0000, 24'hFF0000, 24'hFF0000};
		i_cs_bus16 = 4'hD;
		repeat (5) @(negedge i_clock);
		chk("rst", 3'h1, {o_ale_oe, o_bus_ctrl_oe, o_bus_grant_ack_n});
		i_reset_n = 1'h1;
		@(negedge i_clock);
		foreach (rows[k]) acc(rows[k]);
		// ALE off must not disturb the cycle itself
		i_ale_enable = 1'h0;
		acc(rows[0]);
		i_ale_enable = 1'h1;
		for (int k = 0; k < 4; k++) begin
			@(negedge i_clock);
			{i_read_strobe_pin_latch, i_read_strobe_pin_function_sel} = k[1:0];
			i_int_read = 1'h1;
			@(negedge i_clock);
			chk("int_rd", k != 1, o_read_strobe_n);
			i_int_read = 1'h0;
		end
		i_bus_request_n = 1'h0;
		wait_ack(1'h0);
		chk("float", 2'h0, {o_bus_ctrl_oe, o_muxed_addr_data_oe});
		{i_read_strobe_pin_latch, i_read_strobe_pin_function_sel} = 2'h1;
		{i_req_valid, i_int_read} = 2'h3;
		repeat (3) @(negedge i_clock);
		chk("grant", 2'h3, {o_req_busy, o_read_strobe_n});
		{i_req_valid, i_int_read, i_bus_request_n} = 3'h1;
		wait_ack(1'h1);
		chk("resume", 1'h1, o_bus_ctrl_oe);
		i_reset_n = 1'h0;
		@(negedge i_clock);
		chk("rst", 3'h1, {o_ale_oe, o_bus_ctrl_oe, o_bus_grant_ack_n});
		@(negedge i_clock);
		i_reset_n = 1'h1;
		@(negedge i_clock);
		acc(rows[1]);
		report_and_stop();
	end
endmodule
bind emb_external_bus emb_props #(.CS_N(CS_N)) u_emb_props (.*);
`default_nettype wire
